// [core/slice_regs.svh]
/*
 * Register offsets, field positions and reset values of the 4-bit datapath
 * slice. Assumes inclusion by the slice package users and the slice top module.
 */
`ifndef SLICE_REGS_SVH
`define SLICE_REGS_SVH

// Wishbone byte offsets, one aligned word each
`define SLC_CTRL_OFS 8'h00
`define SLC_STATUS_OFS 8'h04
`define SLC_IRQ_EN_OFS 8'h08
`define SLC_IRQ_CLR_OFS 8'h0C
`define SLC_OBSERVE_OFS 8'h10

// Control register fields
`define SLC_CTRL_RUN_BIT 0
`define SLC_CTRL_RST 1'b0

// Event bits shared by status, enable and clear registers
`define SLC_EV_OVF_BIT 0
`define SLC_EV_COUT_BIT 1
`define SLC_EV_ZERO_BIT 2
`define SLC_EV_WIDTH 3
`define SLC_EV_RST 3'h0

// Observation register fields: aux register, then last result
`define SLC_OBS_AUX_LSB 0
`define SLC_OBS_RES_LSB 4

// Register file geometry
`define SLC_FILE_WORDS 16

`endif

// [core/slice_pkg.sv]
/*
 * Types of the 4-bit datapath slice: microinstruction fields, codes and the
 * ALU answer bundle. Assumes nothing of its surroundings.
 */
package slice_pkg;

   // Source operand pairs (left, right)
   typedef enum logic [2:0] {
      SRC_A_AUX = 3'h0,
      SRC_A_B = 3'h1,
      SRC_Z_AUX = 3'h2,
      SRC_Z_B = 3'h3,
      SRC_Z_A = 3'h4,
      SRC_D_A = 3'h5,
      SRC_D_AUX = 3'h6,
      SRC_D_Z = 3'h7
   } source_t;

   // ALU functions
   typedef enum logic [2:0] {
      FN_ADD = 3'h0,
      FN_SUBR = 3'h1,
      FN_SUBS = 3'h2,
      FN_OR = 3'h3,
      FN_AND = 3'h4,
      FN_NOTRS = 3'h5,
      FN_XOR = 3'h6,
      FN_XNOR = 3'h7
   } function_t;

   // Destination codes
   typedef enum logic [2:0] {
      DST_AUX = 3'h0,
      DST_NONE = 3'h1,
      DST_FILE_A = 3'h2,
      DST_FILE = 3'h3,
      DST_DOWN_BOTH = 3'h4,
      DST_DOWN = 3'h5,
      DST_UP_BOTH = 3'h6,
      DST_UP = 3'h7
   } destination_t;

   // Two phases of the emulated slice clock
   typedef enum logic {
      PH_LOW = 1'b0,
      PH_HIGH = 1'b1
   } phase_t;

   // Nine-bit microinstruction, most significant group first
   typedef struct packed {
      destination_t destination_select;
      function_t function_select;
      source_t source_select;
   } micro_t;

   // ALU answer with carry look-ahead terms
   typedef struct packed {
      logic [3:0] f;
      logic c3;
      logic c4;
      logic gen;
      logic prop;
   } alu_res_t;

endpackage

// [core/slice_datapath.sv]
/*
 * Cascadable 4-bit microprogrammed datapath slice with a Wishbone control
 * and interrupt window. Assumes the microprogram controller and the
 * neighbouring slices run on ref_clk_i, so their inputs need no
 * synchroniser, and that a bench resolves the two-way pins from the enables.
 */
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
//
// Operation
// RULE1 - Sixteen 4-bit words, two independent read addresses
// RULE2 - File write at B address during low
// RULE3 - Port latches transparent high, hold while low
// RULE4 - Aux register loads at rising edge
// RULE5 - Operand muxes choose A/D and A/B/aux
// RULE6 - Source code picks operand pair from table
// RULE7 - Function code picks one of eight operations
// RULE8 - Carry input only affects arithmetic functions
// RULE9 - Group generate, propagate and ripple carry out
// RULE10 - Sign output always shows result top bit
// RULE11 - Zero detect high on zero, open collector
// RULE12 - Overflow when carries into/out of MSB differ
// RULE13 - Output port A or result, tristate by enable
// RULE14 - File shifter drives and takes end ports
// RULE15 - Aux shifter end ports behave likewise
// RULE16 - Destination codes zero to four as tabled
// RULE17 - Codes five to seven halve or double
// RULE18 - Subtract adds complemented operand plus carry
// RULE19 - Cascade wiring joins shift ports and carries
`timescale 1ns/1ps
`default_nettype none
`include "slice_regs.svh"

module slice_datapath (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_stb_i,
   input wire logic wb_cyc_i,
   output logic wb_ack_o,
   input wire slice_pkg::micro_t micro_i,
   input wire logic [3:0] port_a_address_i,
   input wire logic [3:0] port_b_address_i,
   input wire logic [3:0] direct_operand_i,
   input wire logic carry_in_i,
   input wire logic output_enable_n_i,
   input wire logic file_shift_lsb_i,
   output logic file_shift_lsb_o,
   output logic file_shift_lsb_oe_o,
   input wire logic file_shift_msb_i,
   output logic file_shift_msb_o,
   output logic file_shift_msb_oe_o,
   input wire logic aux_shift_lsb_i,
   output logic aux_shift_lsb_o,
   output logic aux_shift_lsb_oe_o,
   input wire logic aux_shift_msb_i,
   output logic aux_shift_msb_o,
   output logic aux_shift_msb_oe_o,
   output logic [3:0] slice_output_o,
   output logic slice_output_oe_o,
   output logic sign_bit_out_o,
   output logic zero_flag_o,
   output logic zero_flag_oe_o,
   output logic overflow_flag_o,
   output logic carry_out_o,
   output logic group_generate_o,
   output logic group_propagate_o,
   output logic irq_o
);
   import slice_pkg::*;

   // ALU core; subtracts add the complemented operand plus carry in
   function automatic alu_res_t alu_calc(input logic [3:0] r, input logic [3:0] s,
                                         input logic cin, input function_t fn);
      logic [3:0] rr;
      logic [3:0] ss;
      logic [3:0] p;
      logic [3:0] g;
      logic [4:0] lo;
      logic [4:0] full;
      alu_res_t res;
      rr = (fn == FN_SUBR) ? ~r : r; // [RULE18]
      ss = (fn == FN_SUBS) ? ~s : s; // [RULE18]
      lo = {2'h0, rr[2:0]} + {2'h0, ss[2:0]} + {4'h0, cin};
      full = {1'h0, rr} + {1'h0, ss} + {4'h0, cin};
      p = rr | ss;
      g = rr & ss;
      res.c3 = lo[3];
      res.c4 = full[4];
      res.gen = g[3] | (p[3] & g[2]) | (p[3] & p[2] & g[1]) | (&p[3:1] & g[0]); // [RULE9]
      res.prop = &p; // [RULE9]
      case (fn) // [RULE7] [RULE8]
         FN_ADD, FN_SUBR, FN_SUBS: res.f = full[3:0];
         FN_OR: res.f = r | s;
         FN_AND: res.f = r & s;
         FN_NOTRS: res.f = ~r & s;
         FN_XOR: res.f = r ^ s;
         FN_XNOR: res.f = ~(r ^ s);
         default: res.f = 4'h0;
      endcase
      return res;
   endfunction

   logic [3:0] file_r [`SLC_FILE_WORDS];
   logic [3:0] latch_a_r;
   logic [3:0] latch_b_r;
   logic [3:0] aux_r;
   phase_t phase_r;
   logic run_r;
   logic [`SLC_EV_WIDTH-1:0] status_r;
   logic [`SLC_EV_WIDTH-1:0] irq_en_r;
   logic [3:0] result_r;
   logic out_is_a_r;
   logic [31:0] rd_nxt;
   logic [3:0] left_op;
   logic [3:0] right_op;
   logic [3:0] file_wdata;
   logic [3:0] aux_wdata;
   logic file_we;
   logic aux_we;
   logic cyc_end;
   logic wb_hit;
   logic [`SLC_EV_WIDTH-1:0] ev_set;
   logic [`SLC_EV_WIDTH-1:0] ev_clr;
   alu_res_t alu;
   destination_t dst;

   assign dst = micro_i.destination_select;
   // End of the low phase stands for the slice clock rising edge
   assign cyc_end = run_r && (phase_r == PH_LOW);

   // Slice clock phase divider; freezes in whichever phase run is cleared
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         phase_r <= PH_HIGH;
      end else if (run_r) begin
         case (phase_r)
            PH_HIGH: phase_r <= PH_LOW;
            PH_LOW: phase_r <= PH_HIGH;
            default: phase_r <= PH_HIGH;
         endcase
      end
   end

   // Port latches follow the file in the high phase so writes cannot race
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         latch_a_r <= 4'h0;
         latch_b_r <= 4'h0;
      end else if (phase_r == PH_HIGH) begin
         latch_a_r <= file_r[port_a_address_i]; // [RULE1] [RULE3]
         latch_b_r <= file_r[port_b_address_i]; // [RULE1] [RULE3]
      end
   end

   // Operand selection; zero stands for an inhibited multiplexer
   always_comb begin
      case (micro_i.source_select) // [RULE5] [RULE6]
         SRC_A_AUX: begin left_op = latch_a_r; right_op = aux_r; end
         SRC_A_B: begin left_op = latch_a_r; right_op = latch_b_r; end
         SRC_Z_AUX: begin left_op = 4'h0; right_op = aux_r; end
         SRC_Z_B: begin left_op = 4'h0; right_op = latch_b_r; end
         SRC_Z_A: begin left_op = 4'h0; right_op = latch_a_r; end
         SRC_D_A: begin left_op = direct_operand_i; right_op = latch_a_r; end
         SRC_D_AUX: begin left_op = direct_operand_i; right_op = aux_r; end
         SRC_D_Z: begin left_op = direct_operand_i; right_op = 4'h0; end
         default: begin left_op = 4'h0; right_op = 4'h0; end
      endcase
   end

   assign alu = alu_calc(left_op, right_op, carry_in_i, micro_i.function_select);

   // Destination decode: shifts take the far end bit from the neighbour pin
   always_comb begin
      file_we = 1'b1;
      aux_we = 1'b0;
      file_wdata = alu.f;
      aux_wdata = alu.f;
      case (dst) // [RULE16] [RULE17]
         DST_AUX: begin file_we = 1'b0; aux_we = 1'b1; end
         DST_NONE: file_we = 1'b0;
         DST_FILE_A, DST_FILE: file_wdata = alu.f;
         DST_DOWN_BOTH: begin
            file_wdata = {file_shift_msb_i, alu.f[3:1]}; // [RULE14]
            aux_wdata = {aux_shift_msb_i, aux_r[3:1]}; // [RULE15]
            aux_we = 1'b1;
         end
         DST_DOWN: file_wdata = {file_shift_msb_i, alu.f[3:1]}; // [RULE14]
         DST_UP_BOTH: begin
            file_wdata = {alu.f[2:0], file_shift_lsb_i}; // [RULE14]
            aux_wdata = {aux_r[2:0], aux_shift_lsb_i}; // [RULE15]
            aux_we = 1'b1;
         end
         DST_UP: file_wdata = {alu.f[2:0], file_shift_lsb_i}; // [RULE14]
         default: file_we = 1'b0;
      endcase
   end

   // File write at the close of the low phase, at the B address
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < `SLC_FILE_WORDS; i++) begin
            file_r[i] <= 4'h0;
         end
      end else if (cyc_end && file_we) begin
         file_r[port_b_address_i] <= file_wdata; // [RULE2]
      end
   end

   // Auxiliary register loads at the emulated rising edge
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         aux_r <= 4'h0;
      end else if (cyc_end && aux_we) begin
         aux_r <= aux_wdata; // [RULE4]
      end
   end

   // Status pins follow the ALU every cycle, one flop behind
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         result_r <= 4'h0;
         out_is_a_r <= 1'b0;
         slice_output_o <= 4'h0;
         slice_output_oe_o <= 1'b0;
         sign_bit_out_o <= 1'b0;
         zero_flag_oe_o <= 1'b0;
         overflow_flag_o <= 1'b0;
         carry_out_o <= 1'b0;
         group_generate_o <= 1'b0;
         group_propagate_o <= 1'b0;
      end else begin
         result_r <= alu.f;
         out_is_a_r <= (dst == DST_FILE_A);
         slice_output_o <= (dst == DST_FILE_A) ? latch_a_r : alu.f; // [RULE13]
         slice_output_oe_o <= !output_enable_n_i; // [RULE13]
         sign_bit_out_o <= alu.f[3]; // [RULE10]
         zero_flag_oe_o <= (alu.f != 4'h0); // [RULE11] pull low when nonzero
         overflow_flag_o <= alu.c3 ^ alu.c4; // [RULE12]
         carry_out_o <= alu.c4; // [RULE9]
         group_generate_o <= alu.gen; // [RULE9]
         group_propagate_o <= alu.prop; // [RULE9]
      end
   end

   // Open collector: the zero pin only ever sinks
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         zero_flag_o <= 1'b0;
      end else begin
         zero_flag_o <= 1'b0; // [RULE11]
      end
   end

   // Shift end ports; undriven without a shift in that direction
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         file_shift_lsb_o <= 1'b0;
         file_shift_lsb_oe_o <= 1'b0;
         file_shift_msb_o <= 1'b0;
         file_shift_msb_oe_o <= 1'b0;
         aux_shift_lsb_o <= 1'b0;
         aux_shift_lsb_oe_o <= 1'b0;
         aux_shift_msb_o <= 1'b0;
         aux_shift_msb_oe_o <= 1'b0;
      end else begin
         file_shift_lsb_o <= alu.f[0];
         file_shift_lsb_oe_o <= (dst == DST_DOWN_BOTH) || (dst == DST_DOWN); // [RULE14]
         file_shift_msb_o <= alu.f[3];
         file_shift_msb_oe_o <= (dst == DST_UP_BOTH) || (dst == DST_UP); // [RULE14]
         aux_shift_lsb_o <= aux_r[0];
         aux_shift_lsb_oe_o <= (dst == DST_DOWN_BOTH) || (dst == DST_DOWN); // [RULE15]
         aux_shift_msb_o <= aux_r[3];
         aux_shift_msb_oe_o <= (dst == DST_UP_BOTH) || (dst == DST_UP); // [RULE15]
      end
   end

   // Wishbone decode; unmapped words ack with zero data and drop writes
   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_hit;
      end
   end

   // Run control and interrupt enable, byte lane 0 only
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         run_r <= `SLC_CTRL_RST;
         irq_en_r <= `SLC_EV_RST;
      end else if (wb_hit && wb_we_i && wb_sel_i[0]) begin
         if (wb_adr_i == `SLC_CTRL_OFS) begin
            run_r <= wb_dat_i[`SLC_CTRL_RUN_BIT];
         end
         if (wb_adr_i == `SLC_IRQ_EN_OFS) begin
            irq_en_r <= wb_dat_i[`SLC_EV_WIDTH-1:0];
         end
      end
   end

   // Sticky events are sampled once per slice cycle
   always_comb begin
      ev_set = '0;
      ev_set[`SLC_EV_OVF_BIT] = cyc_end && (alu.c3 ^ alu.c4);
      ev_set[`SLC_EV_COUT_BIT] = cyc_end && alu.c4;
      ev_set[`SLC_EV_ZERO_BIT] = cyc_end && (alu.f == 4'h0);
      ev_clr = '0;
      if (wb_hit && wb_we_i && wb_sel_i[0] && (wb_adr_i == `SLC_IRQ_CLR_OFS)) begin
         ev_clr = wb_dat_i[`SLC_EV_WIDTH-1:0];
      end
   end

   // A new event beats a clear in the same cycle
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         status_r <= `SLC_EV_RST;
      end else begin
         status_r <= (status_r & ~ev_clr) | ev_set;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status_r & irq_en_r);
      end
   end

   // Read data, registered with the ack
   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (wb_adr_i)
         `SLC_CTRL_OFS: rd_nxt[`SLC_CTRL_RUN_BIT] = run_r;
         `SLC_STATUS_OFS: rd_nxt[`SLC_EV_WIDTH-1:0] = status_r;
         `SLC_IRQ_EN_OFS: rd_nxt[`SLC_EV_WIDTH-1:0] = irq_en_r;
         `SLC_OBSERVE_OFS: begin
            rd_nxt[`SLC_OBS_AUX_LSB +: 4] = aux_r;
            rd_nxt[`SLC_OBS_RES_LSB +: 4] = result_r;
         end
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_hit && !wb_we_i) begin
         wb_dat_o <= rd_nxt;
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   file_write_a: assert property ((cyc_end && file_we) |=> // [RULE2]
      file_r[$past(port_b_address_i)] == $past(file_wdata))
      else $error("file word not written at B address");
   aux_load_a: assert property ((cyc_end && dst == DST_AUX) |=> aux_r == $past(alu.f)) // [RULE4]
      else $error("aux register missed its load");
   latch_hold_a: assert property ((phase_r == PH_LOW) |=> $stable(latch_a_r)) // [RULE3]
      else $error("port latch changed while slice clock low");
   sign_match_a: assert property ((slice_output_oe_o && !out_is_a_r) |-> // [RULE10]
      sign_bit_out_o == slice_output_o[3])
      else $error("sign output differs from output top bit");
   zero_flag_a: assert property (1'b1 |=> (zero_flag_oe_o == ($past(alu.f) != 4'h0))) // [RULE11]
      else $error("zero detect wrong");
   carry_free_a: assert property ((micro_i.function_select >= FN_OR) |-> // [RULE8]
      alu_calc(left_op, right_op, !carry_in_i, micro_i.function_select).f == alu.f)
      else $error("logic result depends on carry in");
   ovf_flag_a: assert property (1'b1 |=> overflow_flag_o == ($past(alu.c3) ^ $past(alu.c4))) // [RULE12]
      else $error("overflow flag wrong");
   msb_drive_a: assert property ((dst == DST_UP || dst == DST_UP_BOTH) |=> // [RULE14]
      file_shift_msb_oe_o && !file_shift_lsb_oe_o && aux_shift_msb_oe_o)
      else $error("shift up ports not driven");
   out_enable_a: assert property (output_enable_n_i |=> !slice_output_oe_o) // [RULE13]
      else $error("output driven while disabled");
   irq_level_a: assert property (1'b1 |=> irq_o == |($past(status_r) & $past(irq_en_r)))
      else $error("interrupt level wrong");

   shift_down_c: cover property (cyc_end && dst == DST_DOWN_BOTH);
   overflow_c: cover property (cyc_end && (alu.c3 ^ alu.c4));
   irq_c: cover property (irq_o ##1 !irq_o);
endmodule
`default_nettype wire

// [verif/cascade_model.sv]
/*
 * Far side of the datapath slice: the neighbouring slices on the four shift
 * end pins and the pull-up on the wire-ORed zero line.
 * Assumes the bench supplies the levels that the neighbours drive.
 */
`timescale 1ns/1ps
`default_nettype none

module cascade_model (
   input wire logic [3:0] drive_oe_i,
   input wire logic [3:0] drive_val_i,
   input wire logic [3:0] nbr_i,
   input wire logic zero_oe_i,
   output logic [3:0] pin_o,
   output logic zero_wire_o
);
   // Each end pin carries the slice driver while enabled, else the neighbour
   assign pin_o = (drive_oe_i & drive_val_i) | (~drive_oe_i & nbr_i);

   // Any slice pulling low wins; otherwise the pull-up holds the line high
   assign zero_wire_o = ~zero_oe_i;
endmodule

`default_nettype wire

// [verif/testbench.sv]
/*
 * Self-checking bench for the 4-bit datapath slice: Wishbone tasks, a
 * microinstruction driver and expected-value arithmetic.
 * Assumes the cascade model resolves the end pins and the zero line.
 */
`timescale 1ns/1ps
`default_nettype none
`include "slice_regs.svh"

module testbench;
   import slice_pkg::*;
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic wb_we_i = 1'b0, wb_stb_i = 1'b0, wb_cyc_i = 1'b0;
   logic [31:0] wb_dat_o, q;
   logic wb_ack_o;
   micro_t micro_i = '0;
   logic [3:0] port_a_address_i = 4'h0, port_b_address_i = 4'h0, direct_operand_i = 4'h0;
   logic carry_in_i = 1'b0, output_enable_n_i = 1'b0;
   logic [3:0] nbr = 4'h0, pins, oe4, val4, slice_output_o;
   logic slice_output_oe_o, sign_bit_out_o, zero_flag_o, zero_flag_oe_o, overflow_flag_o;
   logic carry_out_o, group_generate_o, group_propagate_o, irq_o, zwire;
   int failures = 0;
   int n_compared = 0;
   logic [3:0] mem [16];
   logic [2:0] sv, fv;
   logic cv, c3, gen, prp;
   logic [3:0] r, s, rr, ss, t, p, g, fx;
   logic [4:0] sum;

   slice_datapath slice_datapath_i (
      .ref_clk_i, .resetn_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i,
      .wb_stb_i, .wb_cyc_i, .wb_ack_o, .micro_i, .port_a_address_i, .port_b_address_i,
      .direct_operand_i, .carry_in_i, .output_enable_n_i,
      .file_shift_lsb_i(pins[0]), .file_shift_lsb_o(val4[0]), .file_shift_lsb_oe_o(oe4[0]),
      .file_shift_msb_i(pins[1]), .file_shift_msb_o(val4[1]), .file_shift_msb_oe_o(oe4[1]),
      .aux_shift_lsb_i(pins[2]), .aux_shift_lsb_o(val4[2]), .aux_shift_lsb_oe_o(oe4[2]),
      .aux_shift_msb_i(pins[3]), .aux_shift_msb_o(val4[3]), .aux_shift_msb_oe_o(oe4[3]),
      .slice_output_o, .slice_output_oe_o, .sign_bit_out_o, .zero_flag_o, .zero_flag_oe_o,
      .overflow_flag_o, .carry_out_o, .group_generate_o, .group_propagate_o, .irq_o);

   cascade_model cascade_model_i (.drive_oe_i(oe4), .drive_val_i(val4), .nbr_i(nbr),
      .zero_oe_i(zero_flag_oe_o), .pin_o(pins), .zero_wire_o(zwire));

   // 200 MHz clock
   always #2.5 ref_clk_i = ~ref_clk_i;

   task finish_test;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task chk(input string nm, input logic [7:0] e, input logic [7:0] v);
      n_compared++;
      if (v !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, v);
      end
   endtask

   // One classic cycle: held until ack is sampled, then released for a cycle
   task wb(input logic [7:0] a, input logic [31:0] d, input logic w, input logic [3:0] sl);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_we_i <= w;
      wb_sel_i <= sl;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 50) chk("wb_ack", 8'h01, 8'h00);
   endtask

   task rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
      wb(a, 32'h0, 1'b0, 4'hF);
      chk(nm, e, q[7:0]);
   endtask

   // The bench cannot see the phase, so new addresses reach the latches in a
   // no-write slice cycle first; then the code runs for three slice cycles
   task op(input logic [2:0] dst, fn, src, input logic [3:0] a, b, d, input logic c);
      @(posedge ref_clk_i);
      micro_i <= micro_t'({3'h1, fn, src});
      port_a_address_i <= a;
      port_b_address_i <= b;
      direct_operand_i <= d;
      carry_in_i <= c;
      repeat (2) @(posedge ref_clk_i);
      micro_i.destination_select <= destination_t'(dst);
      repeat (6) @(posedge ref_clk_i);
   endtask

   // Output port A with A = B: the write-back rewrites the same word
   task readback(input logic [3:0] w, input logic [3:0] e, input string nm);
      op(3'h2, 3'h0, 3'h4, w, w, 4'h0, 1'b0);
      chk(nm, {4'h0, e}, {4'h0, slice_output_o});
   endtask

   // Reference arithmetic; file[3], file[12], aux 0xE and direct 0xB
   task alu_model;
      r = (sv < 3'h2) ? mem[3] : (sv < 3'h5) ? 4'h0 : 4'hB;
      case (sv)
         3'h0, 3'h2, 3'h6: s = 4'hE;
         3'h1, 3'h3: s = mem[12];
         3'h7: s = 4'h0;
         default: s = mem[3];
      endcase
      rr = (fv == 3'h1) ? ~r : r;
      ss = (fv == 3'h2) ? ~s : s;
      sum = {1'b0, rr} + {1'b0, ss} + {4'h0, cv};
      t = {1'b0, rr[2:0]} + {1'b0, ss[2:0]} + {3'h0, cv};
      c3 = t[3];
      p = rr | ss;
      g = rr & ss;
      gen = g[3] | (p[3] & g[2]) | (&p[3:2] & g[1]) | (&p[3:1] & g[0]);
      prp = &p;
      case (fv)
         3'h3: fx = r | s;
         3'h4: fx = r & s;
         3'h5: fx = ~r & s;
         3'h6: fx = r ^ s;
         3'h7: fx = ~(r ^ s);
         default: fx = sum[3:0];
      endcase
   endtask

   // Watchdog: the whole run needs under two thousand cycles
   initial begin
      #100000;
      chk("watchdog", 8'h00, 8'h01);
      finish_test();
   end

   initial begin
      repeat (5) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      rd_chk(`SLC_CTRL_OFS, 8'h00, "ctrl_reset");
      rd_chk(`SLC_STATUS_OFS, 8'h00, "status_reset");
      rd_chk(`SLC_IRQ_EN_OFS, 8'h00, "enable_reset");
      rd_chk(`SLC_IRQ_CLR_OFS, 8'h00, "clear_reads_0");
      wb(8'h14, 32'h1, 1'b1, 4'hF);
      rd_chk(8'h14, 8'h00, "unmapped");
      wb(`SLC_CTRL_OFS, 32'h1, 1'b1, 4'hE);
      rd_chk(`SLC_CTRL_OFS, 8'h00, "ctrl_lane0_off");
      wb(`SLC_CTRL_OFS, 32'h1, 1'b1, 4'hF);
      $display("test registers done");
      // Fill all sixteen words, then read each one back
      for (int i = 0; i < 16; i++) begin
         mem[i] = 4'(i) ^ 4'h5;
         op(3'h3, 3'h0, 3'h7, 4'h0, 4'(i), mem[i], 1'b0);
      end
      for (int i = 0; i < 16; i++) readback(4'(i), mem[i], "file_word");
      op(3'h0, 3'h0, 3'h7, 4'h0, 4'h0, 4'hE, 1'b0);
      rd_chk(`SLC_OBSERVE_OFS, 8'hEE, "aux_load");
      op(3'h1, 3'h0, 3'h7, 4'h0, 4'h0, 4'h3, 1'b0);
      rd_chk(`SLC_OBSERVE_OFS, 8'h3E, "aux_hold");
      $display("test file done");
      // Every source pair, function and carry value
      for (int i = 0; i < 128; i++) begin
         sv = i[6:4];
         fv = i[3:1];
         cv = i[0];
         op(3'h1, fv, sv, 4'h3, 4'hC, 4'hB, cv);
         alu_model();
         chk("result", {4'h0, fx}, {4'h0, slice_output_o});
         chk("sign", {7'h0, fx[3]}, {7'h0, sign_bit_out_o});
         chk("zero", {7'h0, fx == 4'h0}, {7'h0, zwire});
         if (fv < 3'h3) chk("flags", {4'h0, sum[4], c3 ^ sum[4], gen, prp},
            {4'h0, carry_out_o, overflow_flag_o, group_generate_o, group_propagate_o});
      end
      output_enable_n_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      chk("y_released", {7'h0, fx[3]}, {6'h0, slice_output_oe_o, sign_bit_out_o});
      output_enable_n_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      chk("y_driven", 8'h01, {7'h0, slice_output_oe_o});
      chk("zero_pin", 8'h00, {7'h0, zero_flag_o});
      $display("test alu done");
      // End pin drivers for each destination code; neighbours drive 0
      for (int k = 0; k < 8; k++) begin
         op(3'(k), 3'h0, 3'h7, 4'h0, 4'hF, 4'h9, 1'b0);
         chk("file_lsb", {6'h0, {2{k == 4 || k == 5}}}, {6'h0, oe4[0], pins[0]});
         chk("file_msb", {6'h0, {2{k > 5}}}, {6'h0, oe4[1], pins[1]});
         chk("aux_oe", {6'h0, k > 5, k == 4 || k == 5}, {6'h0, oe4[3], oe4[2]});
      end
      nbr <= 4'h2;
      op(3'h5, 3'h0, 3'h7, 4'h0, 4'hF, 4'h9, 1'b0);
      readback(4'hF, 4'hC, "half_result");
      nbr <= 4'h1;
      op(3'h7, 3'h0, 3'h7, 4'h0, 4'hF, 4'h9, 1'b0);
      readback(4'hF, 4'h3, "double_result");
      nbr <= 4'h8;
      op(3'h4, 3'h0, 3'h7, 4'h0, 4'hF, 4'h9, 1'b0);
      repeat (6) @(posedge ref_clk_i);
      chk("aux_lsb_out", 8'h03, {6'h0, oe4[2], pins[2]});
      rd_chk(`SLC_OBSERVE_OFS, 8'h9F, "aux_down");
      readback(4'hF, 4'h4, "file_down");
      nbr <= 4'h0;
      op(3'h6, 3'h0, 3'h7, 4'h0, 4'hF, 4'h9, 1'b0);
      repeat (6) @(posedge ref_clk_i);
      rd_chk(`SLC_OBSERVE_OFS, 8'h90, "aux_up");
      readback(4'hF, 4'h2, "file_up");
      $display("test shift done");
      // Sticky events, mask and clear
      wb(`SLC_CTRL_OFS, 32'h0, 1'b1, 4'hF);
      wb(`SLC_IRQ_CLR_OFS, 32'h7, 1'b1, 4'hF);
      wb(`SLC_STATUS_OFS, 32'h7, 1'b1, 4'hF);
      rd_chk(`SLC_STATUS_OFS, 8'h00, "status_cleared");
      wb(`SLC_IRQ_EN_OFS, 32'h4, 1'b1, 4'hF);
      op(3'h1, 3'h0, 3'h7, 4'h0, 4'h0, 4'h7, 1'b1);
      wb(`SLC_CTRL_OFS, 32'h1, 1'b1, 4'hF);
      wb(`SLC_CTRL_OFS, 32'h0, 1'b1, 4'hF);
      rd_chk(`SLC_STATUS_OFS, 8'h01, "status_overflow");
      chk("irq_masked", 8'h00, {7'h0, irq_o});
      op(3'h1, 3'h0, 3'h7, 4'h0, 4'h0, 4'hF, 1'b1);
      wb(`SLC_CTRL_OFS, 32'h1, 1'b1, 4'hF);
      wb(`SLC_CTRL_OFS, 32'h0, 1'b1, 4'hF);
      rd_chk(`SLC_STATUS_OFS, 8'h07, "status_sticky");
      chk("irq_raised", 8'h01, {7'h0, irq_o});
      wb(`SLC_IRQ_EN_OFS, 32'h0, 1'b1, 4'hF);
      repeat (2) @(posedge ref_clk_i);
      chk("irq_disabled", 8'h00, {7'h0, irq_o});
      wb(`SLC_IRQ_CLR_OFS, 32'h7, 1'b1, 4'hF);
      rd_chk(`SLC_STATUS_OFS, 8'h00, "status_clear");
      $display("test irq done");
      finish_test();
   end
endmodule

`default_nettype wire
